// *** dssp_device.sv ***
// device end: serial load port with double-buffered reference ratio
//
// How it works
// - msb first, data sampled on serial clock rise
// - frame length picks config, reference or loop
// - shifting never disturbs programmed registers
// - host keeps loop count at least swallow count
// - low 13 reference bits are double-buffered
// - top 3 reference bits act at once
// - main loop word copies ratio to main hold
// - second loop word copies ratio to second hold
// - one steering bit picks main or second
// - host sends no other length up to 32
// - host holds strobe pulse its minimum width
// - strobe rise commits shifted data by length
// - strobe high clears and holds the shifter
// - strobe changes only while serial clock low
`timescale 1ns/100ps
module dssp_device
  import dssp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  dssp_if.device link,
  output logic [CFG_W-1:0] configMain,
  output logic [CFG_W-1:0] configSecond,
  output logic [REF_W-1:0] refFirstBuffer,
  output logic [REF_MODE_W-1:0] refMode,
  output logic [RATIO_W-1:0] ratioHoldMain,
  output logic [RATIO_W-1:0] ratioHoldSecond,
  output logic [LOOP_W-1:0] loopWordMain,
  output logic [LOOP_W-1:0] loopWordSecond,
  output logic frameLoaded,
  output logic frameDropped
);

  // edge history of the link pins
  logic sclkPrev_q;
  logic sclkPrev_d;
  logic strobePrev_q;
  logic strobePrev_d;

  // shifter and bit count
  logic [LOOP_W-1:0] shift_q;
  logic [LOOP_W-1:0] shift_d;
  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;

  // programmed registers
  logic [CFG_W-1:0] cfgMain_q;
  logic [CFG_W-1:0] cfgMain_d;
  logic [CFG_W-1:0] cfgSecond_q;
  logic [CFG_W-1:0] cfgSecond_d;
  logic [REF_W-1:0] refFirst_q;
  logic [REF_W-1:0] refFirst_d;
  logic [RATIO_W-1:0] holdMain_q;
  logic [RATIO_W-1:0] holdMain_d;
  logic [RATIO_W-1:0] holdSecond_q;
  logic [RATIO_W-1:0] holdSecond_d;
  logic [LOOP_W-1:0] loopMain_q;
  logic [LOOP_W-1:0] loopMain_d;
  logic [LOOP_W-1:0] loopSecond_q;
  logic [LOOP_W-1:0] loopSecond_d;

  // commit reporting pulses
  logic loaded_q;
  logic loaded_d;
  logic dropped_q;
  logic dropped_d;

  // pin decode
  logic framing;
  logic sclkRise;
  logic strobeRise;

  // strobe low opens a frame; edges seen against last cycle's level
  assign framing = ~link.activeLowLoadStrobe_n;
  assign sclkRise = link.serialClk & ~sclkPrev_q;
  assign strobeRise = link.activeLowLoadStrobe_n & ~strobePrev_q;

  // next state of shifter, counter and programmed registers
  always_comb
  begin
    sclkPrev_d = link.serialClk;
    strobePrev_d = link.activeLowLoadStrobe_n;
    shift_d = shift_q;
    count_d = count_q;
    cfgMain_d = cfgMain_q;
    cfgSecond_d = cfgSecond_q;
    refFirst_d = refFirst_q;
    holdMain_d = holdMain_q;
    holdSecond_d = holdSecond_q;
    loopMain_d = loopMain_q;
    loopSecond_d = loopSecond_q;
    loaded_d = 1'b0;
    dropped_d = 1'b0;

    // strobe high keeps the port initialized, no shifting at all
    if (!framing)
    begin
      shift_d = '0;
      count_d = '0;
    end
    else if (sclkRise)
    begin
      // first bit in ends up as the msb of the word
      shift_d = {shift_q[LOOP_W-2:0], link.serialData};
      // saturate so long cascade frames never wrap into a legal count
      if (count_q != COUNT_SAT)
      begin
        count_d = count_q + 6'h01;
      end
    end

    // registers move only here, on the strobe rise
    if (strobeRise)
    begin
      unique case (count_q)
        COUNT_W'(CFG_FRAME_BITS):
        begin
          loaded_d = 1'b1;
          // steering bit picks which config byte
          if (shift_q[CFG_STEER_BIT])
          begin
            cfgSecond_d = shift_q[CFG_W-1:0];
          end
          else
          begin
            cfgMain_d = shift_q[CFG_W-1:0];
          end
        end
        COUNT_W'(REF_FRAME_BITS):
        begin
          loaded_d = 1'b1;
          // whole word to the first buffer; mode bits read out at once
          refFirst_d = shift_q[REF_W-1:0];
        end
        COUNT_W'(LOOP_FRAME_BITS):
        begin
          loaded_d = 1'b1;
          // ratio moves with the loop word so the steered channel's dividers change together
          if (shift_q[LOOP_STEER_BIT])
          begin
            loopSecond_d = shift_q;
            holdSecond_d = refFirst_q[RATIO_W-1:0];
          end
          else
          begin
            loopMain_d = shift_q;
            holdMain_d = refFirst_q[RATIO_W-1:0];
          end
        end
        default:
        begin
          // an empty frame is ignored quietly, any other length reported
          dropped_d = (count_q != '0);
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sclkPrev_q <= 1'b0;
      strobePrev_q <= 1'b1;
      shift_q <= LOOP_RESET;
      count_q <= '0;
      cfgMain_q <= CFG_RESET;
      cfgSecond_q <= CFG_RESET;
      refFirst_q <= REF_RESET;
      holdMain_q <= RATIO_RESET;
      holdSecond_q <= RATIO_RESET;
      loopMain_q <= LOOP_RESET;
      loopSecond_q <= LOOP_RESET;
      loaded_q <= 1'b0;
      dropped_q <= 1'b0;
    end
    else
    begin
      sclkPrev_q <= sclkPrev_d;
      strobePrev_q <= strobePrev_d;
      shift_q <= shift_d;
      count_q <= count_d;
      cfgMain_q <= cfgMain_d;
      cfgSecond_q <= cfgSecond_d;
      refFirst_q <= refFirst_d;
      holdMain_q <= holdMain_d;
      holdSecond_q <= holdSecond_d;
      loopMain_q <= loopMain_d;
      loopSecond_q <= loopSecond_d;
      loaded_q <= loaded_d;
      dropped_q <= dropped_d;
    end
  end

  // outputs straight from flops
  assign configMain = cfgMain_q;
  assign configSecond = cfgSecond_q;
  assign refFirstBuffer = refFirst_q;
  // not double-buffered: follows the first buffer directly
  assign refMode = refFirst_q[REF_MODE_LSB +: REF_MODE_W];
  assign ratioHoldMain = holdMain_q;
  assign ratioHoldSecond = holdSecond_q;
  assign loopWordMain = loopMain_q;
  assign loopWordSecond = loopSecond_q;
  assign frameLoaded = loaded_q;
  assign frameDropped = dropped_q;

  // the divider relation of loop and swallow counts is the host's to
  // keep; the words are stored as sent, unchecked
  // strobe moves while the clock is low, so an edge of the strobe never
  // lands in the same cycle as a clock rise

endmodule

// *** dssp_pkg.sv ***
// constants and helpers shared by both ends of the synthesizer serial port
package dssp_pkg;

  // core clock period
  localparam int CLK_PERIOD_NS = 4;

  // least time in ns to whole core cycles, rounded up, never below one
  function automatic int ns_to_cycles_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // serial clock high and low phase, each at least this long
  localparam int SCLK_MIN_PULSE_NS = 250;
  localparam int SCLK_HALF_CYCLES = ns_to_cycles_min(SCLK_MIN_PULSE_NS);
  // data setup to the rising serial clock edge
  localparam int DATA_SETUP_NS = 50;
  localparam int DATA_SETUP_CYCLES = ns_to_cycles_min(DATA_SETUP_NS);
  // load strobe setup, hold and recovery against the serial clock
  localparam int STROBE_SETUP_NS = 100;
  localparam int STROBE_SETUP_CYCLES = ns_to_cycles_min(STROBE_SETUP_NS);
  // load strobe pulse width, counted in reference or vco periods
  localparam int STROBE_MIN_REF_CYCLES = 3;
  localparam int STROBE_MIN_VCO64_CYCLES = 195;
  localparam int STROBE_MIN_VCO32_CYCLES = 99;

  // frame lengths in serial clocks
  localparam int CFG_FRAME_BITS = 8;
  localparam int REF_FRAME_BITS = 16;
  localparam int LOOP_FRAME_BITS = 24;
  localparam int RESERVED_MAX_BITS = 32;

  // register widths and field positions
  localparam int CFG_W = 8;
  localparam int REF_W = 16;
  localparam int LOOP_W = 24;
  localparam int RATIO_W = 13;
  localparam int REF_MODE_LSB = 13;
  localparam int REF_MODE_W = 3;
  localparam int CFG_STEER_BIT = 7;
  localparam int LOOP_STEER_BIT = 23;

  // bit counter, saturates above the reserved range
  localparam int COUNT_W = 6;
  localparam logic [COUNT_W-1:0] COUNT_SAT = 6'h21;

  // reset values
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
  localparam logic [REF_W-1:0] REF_RESET = 16'h0000;
  localparam logic [LOOP_W-1:0] LOOP_RESET = 24'h000000;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 13'h0000;

endpackage

// *** dssp_if.sv ***
// serial programming link between host and synthesizer
`timescale 1ns/100ps
interface dssp_if;
  logic serialClk;
  logic serialData;
  logic activeLowLoadStrobe_n;

  modport host (
    output serialClk,
    output serialData,
    output activeLowLoadStrobe_n
  );

  modport device (
    input serialClk,
    input serialData,
    input activeLowLoadStrobe_n
  );
endinterface

// *** dssp_host.sv ***
// host end: frames words onto the serial load link
`timescale 1ns/100ps
module dssp_host
  import dssp_pkg::*;
#(
  parameter int REF_PERIOD_NS = 250,
  parameter int VCO_PERIOD_NS = 25
)
(
  input wire logic core_clk,
  input wire logic rst,
  dssp_if.host link,
  input wire logic frameStart,
  input wire logic [COUNT_W-1:0] frameLength,
  input wire logic [LOOP_W-1:0] frameData,
  output logic frameReady,
  output logic frameDone,
  output logic frameRefused
);

  // strobe pulse: greatest of the reference and vco figures
  localparam int STROBE_REF_NS = STROBE_MIN_REF_CYCLES * REF_PERIOD_NS;
  localparam int STROBE_V64_NS = STROBE_MIN_VCO64_CYCLES * VCO_PERIOD_NS;
  localparam int STROBE_V32_NS = STROBE_MIN_VCO32_CYCLES * VCO_PERIOD_NS;
  localparam int STROBE_A_NS =
    (STROBE_REF_NS > STROBE_V64_NS) ? STROBE_REF_NS : STROBE_V64_NS;
  localparam int STROBE_PULSE_NS =
    (STROBE_A_NS > STROBE_V32_NS) ? STROBE_A_NS : STROBE_V32_NS;
  localparam int STROBE_PULSE_CYCLES = ns_to_cycles_min(STROBE_PULSE_NS);
  // a clock phase also covers the data setup time
  localparam int PHASE_CYCLES = (SCLK_HALF_CYCLES > DATA_SETUP_CYCLES) ?
    SCLK_HALF_CYCLES : DATA_SETUP_CYCLES;

  typedef enum logic [2:0] {
    IDLE = 3'b000,
    LEAD = 3'b001,
    LOW = 3'b010,
    HIGH = 3'b011,
    TAIL = 3'b100,
    GAP = 3'b101
  } dssp_host_state_t;

  dssp_host_state_t state_q;
  dssp_host_state_t state_d;
  logic [15:0] wait_q;
  logic [15:0] wait_d;
  logic [LOOP_W-1:0] shift_q;
  logic [LOOP_W-1:0] shift_d;
  logic [COUNT_W-1:0] left_q;
  logic [COUNT_W-1:0] left_d;
  logic sclk_q;
  logic sclk_d;
  logic strobe_q;
  logic strobe_d;
  logic done_q;
  logic done_d;
  logic refused_q;
  logic refused_d;
  logic legalLen;

  // only the three documented lengths go out
  assign legalLen = (frameLength == COUNT_W'(CFG_FRAME_BITS)) ||
    (frameLength == COUNT_W'(REF_FRAME_BITS)) ||
    (frameLength == COUNT_W'(LOOP_FRAME_BITS));

  // framing sequence
  always_comb
  begin
    state_d = state_q;
    wait_d = (wait_q != 16'h0000) ? wait_q - 16'h0001 : wait_q;
    shift_d = shift_q;
    left_d = left_q;
    sclk_d = sclk_q;
    strobe_d = strobe_q;
    done_d = 1'b0;
    refused_d = 1'b0;
    unique case (state_q)
      IDLE:
      begin
        if (frameStart && !legalLen)
        begin
          refused_d = 1'b1;
        end
        else if (frameStart)
        begin
          // left-justify so the msb leaves first
          shift_d = frameData << (COUNT_W'(LOOP_FRAME_BITS) - frameLength);
          left_d = frameLength;
          strobe_d = 1'b0;
          wait_d = 16'(STROBE_SETUP_CYCLES);
          state_d = LEAD;
        end
      end
      LEAD:
      begin
        if (wait_q == 16'h0000)
        begin
          wait_d = 16'(PHASE_CYCLES);
          state_d = LOW;
        end
      end
      LOW:
      begin
        if (wait_q == 16'h0000)
        begin
          sclk_d = 1'b1;
          wait_d = 16'(PHASE_CYCLES);
          state_d = HIGH;
        end
      end
      HIGH:
      begin
        if (wait_q == 16'h0000)
        begin
          // data changes on the fall, well away from the sampling rise
          sclk_d = 1'b0;
          shift_d = {shift_q[LOOP_W-2:0], 1'b0};
          left_d = left_q - 6'h01;
          wait_d = 16'(PHASE_CYCLES);
          state_d = (left_q == 6'h01) ? TAIL : LOW;
        end
      end
      TAIL:
      begin
        if (wait_q == 16'h0000)
        begin
          strobe_d = 1'b1;
          wait_d = 16'(STROBE_PULSE_CYCLES);
          state_d = GAP;
        end
      end
      GAP:
      begin
        // strobe stays high its minimum width before a new frame
        if (wait_q == 16'h0000)
        begin
          done_d = 1'b1;
          state_d = IDLE;
        end
      end
      default:
      begin
        state_d = IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= IDLE;
      wait_q <= 16'h0000;
      shift_q <= LOOP_RESET;
      left_q <= '0;
      sclk_q <= 1'b0;
      strobe_q <= 1'b1;
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      wait_q <= wait_d;
      shift_q <= shift_d;
      left_q <= left_d;
      sclk_q <= sclk_d;
      strobe_q <= strobe_d;
      done_q <= done_d;
      refused_q <= refused_d;
    end
  end

  assign link.serialClk = sclk_q;
  assign link.serialData = shift_q[LOOP_W-1];
  assign link.activeLowLoadStrobe_n = strobe_q;
  assign frameReady = (state_q == IDLE);
  assign frameDone = done_q;
  assign frameRefused = refused_q;

endmodule

// *** dssp_link_assertions.sv ***
// checker for the serial load link and the device commit pulses
`timescale 1ns/100ps
module dssp_link_assertions
  import dssp_pkg::*;
#(
  parameter int STROBE_MIN_CYC = 49
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic activeLowLoadStrobe_n,
  input wire logic frameLoaded,
  input wire logic frameDropped,
  input wire logic [REF_W-1:0] refFirstBuffer,
  input wire logic [REF_MODE_W-1:0] refMode
);
  logic [15:0] hiCnt_q;
  logic [15:0] hiCnt_d;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // strobe high time, saturates so idle gaps never wrap
  always_comb
  begin
    hiCnt_d = !activeLowLoadStrobe_n ? 16'h0000 :
      (&hiCnt_q) ? hiCnt_q : hiCnt_q + 16'h0001;
  end

  // reset counts as a long idle strobe
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      hiCnt_q <= 16'hffff;
    else
      hiCnt_q <= hiCnt_d;
  end

  a_data_steady_high: assert property (
    serialClk && $past(serialClk) |-> $stable(serialData))
    else $error("data moved while serial clock high");
  a_strobe_moves_low: assert property (
    $changed(activeLowLoadStrobe_n) |-> !serialClk && !$past(serialClk))
    else $error("strobe moved with clock high");
  a_idle_clock_low: assert property (
    activeLowLoadStrobe_n |-> !serialClk)
    else $error("serial clock high outside frame");
  a_strobe_min_width: assert property (
    $fell(activeLowLoadStrobe_n) |-> hiCnt_q >= STROBE_MIN_CYC)
    else $error("strobe pulse too short");
  a_commit_follows: assert property (
    $rose(activeLowLoadStrobe_n) |=> frameLoaded || frameDropped)
    else $error("no commit after strobe rise");
  a_commit_cause: assert property (
    frameLoaded |->
      $past(activeLowLoadStrobe_n) && !$past(activeLowLoadStrobe_n, 2))
    else $error("commit without strobe rise");
  a_hold_while_shift: assert property (
    !activeLowLoadStrobe_n |-> $stable(refFirstBuffer))
    else $error("register moved during shifting");
  // a mode change that waits for a loop word would trip this
  a_mode_immediate: assert property (
    $changed(refMode) |-> $changed(refFirstBuffer))
    else $error("mode bits not immediate");
  a_pulse_single: assert property (
    frameLoaded |=> !frameLoaded && !frameDropped)
    else $error("commit pulse too long");

  c_commit: cover property (frameLoaded);
  c_strobe_rise: cover property ($rose(activeLowLoadStrobe_n));
  c_mode_change: cover property ($changed(refMode));
endmodule

// *** tb.sv ***
// bench: host and device on one link, raw driver on a second
`timescale 1ns/100ps
module tb;
  import dssp_pkg::*;
  localparam int SW = 109;
  localparam int LIMIT = 60000;
  localparam int STRB = (STROBE_MIN_VCO64_CYCLES + 3) / 4;
  logic core_clk, rst, frameStart, frameReady, frameDone, frameRefused;
  logic [COUNT_W-1:0] frameLength;
  logic [LOOP_W-1:0] frameData, r1, r2, lwM, lwS, eLM, eLS, wBits, wm, we;
  logic [CFG_W-1:0] cfgM, cfgS, cfg2, eCM, eCS;
  logic [REF_W-1:0] refB, eRef;
  logic [REF_MODE_W-1:0] refMode;
  logic [RATIO_W-1:0] rhM, rhS, eRM, eRS;
  logic loaded, dropped, loaded2, dropped2;
  logic [SW-1:0] st;
  logic [SW-1:0] sq[$];
  logic [29:0] wq[$];
  logic [29:0] w;
  int bad_count, checked, cyc, wCnt, drop2, load2;
  dssp_if l1();
  dssp_if l2();
  dssp_host #(.REF_PERIOD_NS(4), .VCO_PERIOD_NS(1)) dssp_host_inst (
    .core_clk(core_clk), .rst(rst), .link(l1), .frameStart(frameStart),
    .frameLength(frameLength), .frameData(frameData),
    .frameReady(frameReady), .frameDone(frameDone),
    .frameRefused(frameRefused));
  dssp_device dssp_device_inst (
    .core_clk(core_clk), .rst(rst), .link(l1), .configMain(cfgM),
    .configSecond(cfgS), .refFirstBuffer(refB), .refMode(refMode),
    .ratioHoldMain(rhM), .ratioHoldSecond(rhS), .loopWordMain(lwM),
    .loopWordSecond(lwS), .frameLoaded(loaded), .frameDropped(dropped));
  // second device fed by a driver that breaks the length rules
  dssp_device dssp_device_inst2 (
    .core_clk(core_clk), .rst(rst), .link(l2), .configMain(cfg2),
    .configSecond(), .refFirstBuffer(), .refMode(), .ratioHoldMain(),
    .ratioHoldSecond(), .loopWordMain(), .loopWordSecond(),
    .frameLoaded(loaded2), .frameDropped(dropped2));
  dssp_link_assertions #(.STROBE_MIN_CYC(STRB)) chk (
    .core_clk(core_clk), .rst(rst), .serialClk(l1.serialClk),
    .serialData(l1.serialData),
    .activeLowLoadStrobe_n(l1.activeLowLoadStrobe_n),
    .frameLoaded(loaded), .frameDropped(dropped),
    .refFirstBuffer(refB), .refMode(refMode));

  // whole programmed state of the first device, in note order
  assign st = {cfgM, cfgS, refB, refMode, rhM, rhS, lwM, lwS};

  task automatic chk_state(input logic [SW-1:0] g, input logic [SW-1:0] e);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, g, e);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // model the commit, note it, then hand the word to the host
  task automatic hsend(input logic [5:0] n, input logic [23:0] d);
    int k;
    logic ok;
    k = 0;
    ok = (n == 6'h08) || (n == 6'h10) || (n == 6'h18);
    case (n)
      6'h08:
        if (d[CFG_STEER_BIT]) eCS = d[7:0];
        else eCM = d[7:0];
      6'h10: eRef = d[15:0];
      6'h18:
        if (d[LOOP_STEER_BIT]) {eLS, eRS} = {d, eRef[12:0]};
        else {eLM, eRM} = {d, eRef[12:0]};
      default: ;
    endcase
    if (ok)
    begin
      sq.push_back({eCM, eCS, eRef, eRef[15:13], eRM, eRS, eLM, eLS});
      wq.push_back({n, d});
    end
    @(negedge core_clk);
    frameStart = 1'b1;
    frameLength = n;
    frameData = d;
    @(negedge core_clk);
    frameStart = 1'b0;
    // a taken frame leaves the host busy, a refused one idle
    chk_bit(frameReady, !ok);
    while (frameDone !== 1'b1 && frameRefused !== 1'b1 && k < 5000)
    begin
      @(negedge core_clk);
      k++;
    end
    chk_bit(frameRefused, !ok);
    chk_bit(frameDone, ok);
    @(negedge core_clk);
  endtask

  // raw frame of any length on the second link, msb first
  task automatic rawf(input int n, input logic [39:0] d);
    l2.activeLowLoadStrobe_n = 1'b0;
    repeat (SCLK_HALF_CYCLES) @(negedge core_clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      l2.serialData = d[i];
      repeat (SCLK_HALF_CYCLES) @(negedge core_clk);
      l2.serialClk = 1'b1;
      repeat (SCLK_HALF_CYCLES) @(negedge core_clk);
      l2.serialClk = 1'b0;
    end
    repeat (SCLK_HALF_CYCLES) @(negedge core_clk);
    l2.activeLowLoadStrobe_n = 1'b1;
    l2.serialData = ~l2.serialData; // released line shows no stale bit
    repeat (SCLK_HALF_CYCLES) @(negedge core_clk);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      bad_count++;
      wrap_up();
    end
  end

  // scoreboard: oldest note against each committed frame
  always @(negedge core_clk)
  begin
    if (dropped2 === 1'b1) drop2++;
    if (loaded2 === 1'b1) load2++;
    // the host only sends legal lengths, so no drop may show here
    if (dropped === 1'b1)
      chk_bit(dropped, 1'b0);
    if (loaded === 1'b1)
    begin
      if (sq.size() == 0)
        chk_bit(1'b1, 1'b0);
      else
        chk_state(st, sq.pop_front());
    end
  end

  // wire watch: bits captured on serial clock rise
  always @(posedge l1.serialClk)
    if (l1.activeLowLoadStrobe_n === 1'b0)
    begin
      wBits = {wBits[22:0], l1.serialData};
      wCnt++;
    end
  always @(negedge l1.activeLowLoadStrobe_n) wCnt = 0;
  always @(posedge l1.activeLowLoadStrobe_n)
    if (wq.size() > 0)
    begin
      w = wq.pop_front();
      wm = wBits << (24 - w[29:24]);
      we = w[23:0] << (24 - w[29:24]);
      chk_state(SW'(wCnt), SW'(w[29:24]));
      chk_state(SW'(wm), SW'(we));
      chk_bit(l1.serialClk, 1'b0);
    end

  initial
  begin
    {frameStart, frameLength, frameData, wBits, wCnt} = '0;
    {eCM, eCS, eRef, eRM, eRS, eLM, eLS} = '0;
    {l2.serialClk, l2.serialData, l2.activeLowLoadStrobe_n} = 3'h1;
    void'($urandom(83412));
    rst = 1'b1;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk_state(st, '0);
    r1 = 24'($urandom);
    r2 = 24'($urandom);
    hsend(6'h10, r1);
    hsend(6'h18, {1'b0, r2[22:0]});
    hsend(6'h10, ~r1);
    hsend(6'h18, {1'b1, r1[22:0]});
    hsend(6'h08, {16'h0000, 1'b0, r2[6:0]});
    hsend(6'h08, {16'h0000, 1'b1, r1[6:0]});
    hsend(6'h0c, r2);
    hsend(6'h20, r1);
    rawf(8, {32'h0, 1'b0, r2[6:0]});
    rawf(12, {16'h0, r1});
    rawf(40, {r2[15:0], r1});
    chk_state(SW'(cfg2), SW'({1'b0, r2[6:0]}));
    chk_state(SW'(drop2), SW'(2));
    chk_state(SW'(load2), SW'(1));
    // every noted commit and every noted wire frame must have shown up
    chk_state(SW'(sq.size()), '0);
    chk_state(SW'(wq.size()), '0);
    wrap_up();
  end
endmodule
